/* File: sic_top.sv */
// Purpose: Safety interlock supervisor for a high-voltage pulse generator.
// Assumes: Inputs synchronous to aclk in timing sense, but still re-registered.
//          Threshold comparators sit outside; a high digital level means open.
// Notes:   Registers on AXI4-Lite; all outputs come from the state register.
//          Mode and supply are never brought back on their own when the loop recloses.
//          DEB_CYCLES sets the closing filter; shorten it only in simulation.
//
// Contract
// - Run or external-trigger armed requests are refused while the loop is open.
// - Loop opening during run forces stop and leaves run at once.
// - Test object supply cannot switch on while the loop is open.
// - Loop opening with supply on switches the supply off.
// - Closed loop: green lamp off, red lamp on; open loop the reverse.
// - Open loop shows the open-switch symbol on the display.
// - High voltage and supply enable only when every unit reports safe.
// - All interlock signals are active low, asserted when grounded.
// - An open contact or input above threshold counts as open loop.
// - Lamp and peripheral output asserts once the instrument leaves standby.
// - Emergency stop or internal interlock breaks the loop-through path.
// - Interlock status input drives the interlock function as loop state.
// - Interlock state changes are reported as status messages.
// - An interlock output lets chained equipment follow the interlock state.
// - Internal emergency-off button opens the loop like an open contact.
// - Open loop reports the interlock-open status code.
`timescale 1ns/1ns
`default_nettype none
`include "sic_cfg.svh"

module sic_top
    import sic_pkg::*;
#(
    parameter logic [`SIC_DEB_W-1:0] DEB_CYCLES = `SIC_DEB_W'(`SIC_DEB_CYCLES)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic loop_in_n,
    input wire logic loop_status_n,
    input wire logic estop_released_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic run_active,
    output logic external_trigger_armed_mode,
    output logic test_object_supply,
    output logic lamp_red,
    output logic lamp_green,
    output logic open_symbol,
    output logic periph_on,
    output logic loop_through,
    output logic ilk_out_n,
    output logic msg_valid,
    output logic [7:0] msg_code
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Unmapped offsets decode to NONE and are answered with a slave error.
    function automatic sic_reg_t sic_decode(input logic [7:0] addr);
        sic_reg_t r;
        r = SIC_REG_NONE;
        unique case (addr)
            `SIC_OFF_CTRL: r = SIC_REG_CTRL;
            `SIC_OFF_CMD: r = SIC_REG_CMD;
            `SIC_OFF_STAT: r = SIC_REG_STAT;
            `SIC_OFF_EVT: r = SIC_REG_EVT;
            default: r = SIC_REG_NONE;
        endcase
        return r;
    endfunction

    sic_state_t q;
    sic_state_t d;

    // Helpers of the next-state logic; none of them is stored.
    logic [2:0] good;
    logic closed;
    logic wr_fire;
    sic_reg_t wr_reg;
    sic_reg_t rd_reg;
    logic [4:0] cmd;
    logic [3:0] evt_clr;
    logic [3:0] evt_set;
    logic ok_to_enable;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.msg_valid = 1'b0;
        cmd = 5'h00;
        evt_clr = 4'h0;
        evt_set = 4'h0;

        // --------------------------------------------------------------
        // Input synchronisers and debounce
        // --------------------------------------------------------------
        // The first stage is read by nothing but the second, so a metastable
        // level can only reach the logic through two flip-flops.
        // Bit 0: loop contact, bit 1: status line, bit 2: emergency-off released.
        d.s1 = {estop_released_n, loop_status_n, loop_in_n};
        d.s2 = q.s1;
        // A grounded line is asserted; a floating or high line reads as open.
        good = {~q.s2[2], ~q.s2[1], ~q.s2[0]};

        // Opening takes effect on the first synchronised sample; only closing
        // waits out the bounce time, so contact chatter can never enable HV.
        // The counter stops once a line is accepted, so it cannot wrap while
        // a contact stays closed.
        for (int i = 0; i < 3; i++) begin
            if (!good[i]) begin
                d.deb[i] = 1'b0;
                d.cnt[i] = '0;
            end else if (!q.deb[i]) begin
                if (q.cnt[i] >= DEB_CYCLES - `SIC_DEB_W'(1)) begin
                    d.deb[i] = 1'b1;
                end else begin
                    d.cnt[i] = q.cnt[i] + `SIC_DEB_W'(1);
                end
            end
        end

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        // Address and data are taken in either order and parked until both
        // are in; the response follows one cycle later. Holding both ready
        // lines low until the response is taken limits the bus to one write
        // in flight, so two command pulses can never overlap.
        // A write to the status register is answered and dropped.
        if (s_axi_awvalid && q.awready) begin
            d.awready = 1'b0;
            d.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.wready = 1'b0;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        wr_fire = !q.awready && !q.wready && !q.bvalid;
        wr_reg = sic_decode(q.waddr);
        if (wr_fire) begin
            d.bvalid = 1'b1;
            d.bresp = (wr_reg == SIC_REG_NONE) ? `SIC_RESP_SLVERR : `SIC_RESP_OKAY;
            // Only byte lane 0 carries register bits; a write without it is
            // answered but changes nothing.
            if (q.wstrb[0]) begin
                unique case (wr_reg)
                    SIC_REG_CTRL: begin
                        d.power = q.wdata[`SIC_CTRL_POWER];
                        d.int_ilk = q.wdata[`SIC_CTRL_INT_ILK];
                    end
                    SIC_REG_CMD: cmd = q.wdata[4:0];
                    SIC_REG_EVT: evt_clr = q.wdata[3:0];
                    SIC_REG_STAT: ;
                    SIC_REG_NONE: ;
                endcase
            end
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
            d.awready = 1'b1;
            d.wready = 1'b1;
        end

        // --------------------------------------------------------------
        // Loop state and operating mode
        // --------------------------------------------------------------
        // The whole chain must report safe: contact, status line and
        // emergency-off, and the internal interlock must be released.
        // A write that sets int_ilk opens the loop in the cycle it lands.
        closed = &d.deb && !d.int_ilk;
        d.closed = closed;
        // Standby counts as unsafe for the high-voltage side as well.
        ok_to_enable = closed && d.power;

        // Mode and supply are not restored when the loop closes again; the
        // operator asks for them afresh, so a door that swings shut cannot
        // restart the generator.
        if (!ok_to_enable) begin
            if (q.mode != SIC_MODE_STOP) begin
                evt_set[`SIC_EVT_FSTOP] = 1'b1;
            end
            d.mode = SIC_MODE_STOP;
            if (q.supply_on) begin
                evt_set[`SIC_EVT_CUT] = 1'b1;
            end
            d.supply_on = 1'b0;
            // A refused request leaves a sticky flag, so software can tell a
            // dropped command from one lost on the bus.
            if (cmd[`SIC_CMD_RUN] || cmd[`SIC_CMD_ARM] || cmd[`SIC_CMD_SUP_ON]) begin
                evt_set[`SIC_EVT_REFUSED] = 1'b1;
            end
        end else begin
            // Stop outranks the two start requests; run outranks arming.
            priority case (1'b1)
                cmd[`SIC_CMD_STOP]: d.mode = SIC_MODE_STOP;
                cmd[`SIC_CMD_RUN]: d.mode = SIC_MODE_RUN;
                cmd[`SIC_CMD_ARM]: d.mode = SIC_MODE_EXT_ARMED;
                default: d.mode = q.mode;
            endcase
            if (cmd[`SIC_CMD_SUP_OFF]) begin
                d.supply_on = 1'b0;
            end else if (cmd[`SIC_CMD_SUP_ON]) begin
                d.supply_on = 1'b1;
            end
        end

        // --------------------------------------------------------------
        // Event flags and status messages
        // --------------------------------------------------------------
        // Flag order: loop change, request refused, forced stop, supply cut.
        // A change of loop state is also sent out as a one-cycle message.
        if (closed != q.closed) begin
            evt_set[`SIC_EVT_CHANGE] = 1'b1;
            d.msg_valid = 1'b1;
        end
        // A new event in the clearing cycle survives the clear.
        d.evt = (q.evt & ~evt_clr) | evt_set;

        // --------------------------------------------------------------
        // Indicators and chained outputs
        // --------------------------------------------------------------
        // Every indicator follows the filtered loop state of this cycle, so
        // the lamps, the symbol and the chained output never disagree with
        // the mode logic, not even for one cycle.
        // Red means closed and ready for high voltage; green means safe to enter.
        d.lamp_red = closed;
        d.lamp_green = !closed;
        d.open_symbol = !closed;
        d.msg_code = closed ? `SIC_CODE_OK : `SIC_CODE_OPEN;
        d.periph_on = d.power;
        // Only emergency-off and the internal interlock break the through
        // path; an open contact further along the chain is passed on as it is.
        d.loop_through = d.deb[2] && !d.int_ilk;
        d.ilk_out_n = !closed;
        // Mode decodes are registered so that the mode pins are plain flops.
        d.run_active = (d.mode == SIC_MODE_RUN);
        d.ext_armed = (d.mode == SIC_MODE_EXT_ARMED);

        // --------------------------------------------------------------
        // Register reads
        // --------------------------------------------------------------
        // A read is answered one cycle after its address is taken. The
        // status word carries the synchronised raw lines too, so software
        // can tell a chattering contact from one that is simply open.
        // Reads have no side effects; event flags clear only by writing ones.
        rd_reg = sic_decode(s_axi_araddr);
        if (s_axi_arvalid && q.arready) begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = `SIC_RESP_OKAY;
            d.rdata = 32'h00000000;
            unique case (rd_reg)
                SIC_REG_CTRL: begin
                    d.rdata[`SIC_CTRL_POWER] = q.power;
                    d.rdata[`SIC_CTRL_INT_ILK] = q.int_ilk;
                end
                // Command bits are pulses and read back as zero.
                SIC_REG_CMD: ;
                SIC_REG_STAT: begin
                    d.rdata[`SIC_STAT_CLOSED] = q.closed;
                    d.rdata[`SIC_STAT_MODE +: 2] = q.mode;
                    d.rdata[`SIC_STAT_SUPPLY] = q.supply_on;
                    d.rdata[`SIC_STAT_RED] = q.lamp_red;
                    d.rdata[`SIC_STAT_GREEN] = q.lamp_green;
                    d.rdata[`SIC_STAT_SYMBOL] = q.open_symbol;
                    d.rdata[`SIC_STAT_PERIPH] = q.periph_on;
                    d.rdata[`SIC_STAT_THROUGH] = q.loop_through;
                    d.rdata[`SIC_STAT_LINES +: 3] = q.s2;
                    d.rdata[`SIC_STAT_CODE +: 8] = q.msg_code;
                end
                SIC_REG_EVT: d.rdata[3:0] = q.evt;
                SIC_REG_NONE: d.rresp = `SIC_RESP_SLVERR;
            endcase
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // The mode, the supply and the bus answers all start at zero.
            q <= '0;
            // Inputs start as open so nothing is enabled before the
            // debounce has seen a stable, closed chain.
            q.s1 <= 3'h7;
            q.s2 <= 3'h7;
            q.lamp_green <= 1'b1;
            q.open_symbol <= 1'b1;
            q.ilk_out_n <= 1'b1;
            q.msg_code <= `SIC_CODE_OPEN;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    // The mode decodes are held in the state, so every pin is a plain
    // flip-flop output with no logic in front of it.
    assign run_active = q.run_active;
    assign external_trigger_armed_mode = q.ext_armed;
    assign test_object_supply = q.supply_on;
    assign lamp_red = q.lamp_red;
    assign lamp_green = q.lamp_green;
    assign open_symbol = q.open_symbol;
    assign periph_on = q.periph_on;
    assign loop_through = q.loop_through;
    assign ilk_out_n = q.ilk_out_n;
    // The message strobe stands for one cycle; the code is a level.
    assign msg_valid = q.msg_valid;
    assign msg_code = q.msg_code;

endmodule
`default_nettype wire

/* File: sic_cfg.svh */
// Purpose: Register offsets, field positions, status and bus response codes and timing counts for the
//          safety interlock supervisor.
// Assumes: 25 MHz system clock.
// Notes:   Definitions only.
`ifndef SIC_CFG_SVH
`define SIC_CFG_SVH

`define SIC_CLK_MHZ 25
`define SIC_DEB_US 100
`define SIC_DEB_CYCLES ((`SIC_DEB_US) * (`SIC_CLK_MHZ))
`define SIC_DEB_W 16

`define SIC_OFF_CTRL 8'h00
`define SIC_OFF_CMD 8'h04
`define SIC_OFF_STAT 8'h08
`define SIC_OFF_EVT 8'h0C

`define SIC_CTRL_POWER 0
`define SIC_CTRL_INT_ILK 1

`define SIC_CMD_RUN 0
`define SIC_CMD_ARM 1
`define SIC_CMD_STOP 2
`define SIC_CMD_SUP_ON 3
`define SIC_CMD_SUP_OFF 4

`define SIC_EVT_CHANGE 0
`define SIC_EVT_REFUSED 1
`define SIC_EVT_FSTOP 2
`define SIC_EVT_CUT 3

`define SIC_STAT_CLOSED 0
`define SIC_STAT_MODE 1
`define SIC_STAT_SUPPLY 3
`define SIC_STAT_RED 4
`define SIC_STAT_GREEN 5
`define SIC_STAT_SYMBOL 6
`define SIC_STAT_PERIPH 7
`define SIC_STAT_THROUGH 8
`define SIC_STAT_LINES 9
`define SIC_STAT_CODE 16

`define SIC_CODE_OK 8'h00
`define SIC_CODE_OPEN 8'h06
`define SIC_RESP_OKAY 2'h0
`define SIC_RESP_SLVERR 2'h2

`endif

/* File: sic_pkg.sv */
// Purpose: Types shared by the safety interlock supervisor.
// Assumes: Widths from sic_cfg.svh.
// Notes:   Holds types only.
`include "sic_cfg.svh"

package sic_pkg;

    typedef enum logic [1:0] {
        SIC_MODE_STOP = 2'b00,
        SIC_MODE_RUN = 2'b01,
        SIC_MODE_EXT_ARMED = 2'b10
    } sic_mode_t;

    typedef enum logic [2:0] {
        SIC_REG_CTRL = 3'b000,
        SIC_REG_CMD = 3'b001,
        SIC_REG_STAT = 3'b010,
        SIC_REG_EVT = 3'b011,
        SIC_REG_NONE = 3'b100
    } sic_reg_t;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] deb;
        logic [2:0][`SIC_DEB_W-1:0] cnt;
        logic closed;
        logic power;
        logic int_ilk;
        sic_mode_t mode;
        logic run_active;
        logic ext_armed;
        logic supply_on;
        logic [3:0] evt;
        logic lamp_red;
        logic lamp_green;
        logic open_symbol;
        logic periph_on;
        logic loop_through;
        logic ilk_out_n;
        logic msg_valid;
        logic [7:0] msg_code;
        logic awready;
        logic wready;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sic_state_t;

endpackage

/* File: sic_contacts.sv */
// Purpose: Far-side model of the interlock contacts, status line and emergency-off line.
// Assumes: Lines are pulled up, so an open contact reads high.
// Notes:   A closing contact chatters for a few cycles before it settles low.
`timescale 1ns/1ns
`default_nettype none
module sic_contacts (
    input wire logic aclk,
    input wire logic [2:0] open_req,
    output logic loop_in_n,
    output logic loop_status_n,
    output logic estop_released_n
);
    logic [2:0] line_q = 3'b111;
    logic [1:0] bnc_q [3] = '{2'h0, 2'h0, 2'h0};
    // Bounce is kept short so the design's filter, not the bench, decides when it closes.
    always @(posedge aclk) begin
        for (int i = 0; i < 3; i++) begin
            line_q[i] <= open_req[i] | bnc_q[i][0];
            bnc_q[i] <= open_req[i] ? 2'h3 : bnc_q[i] - {1'b0, bnc_q[i] != 2'h0};
        end
    end
    assign loop_in_n = line_q[0];
    assign loop_status_n = line_q[1];
    assign estop_released_n = line_q[2];
endmodule
`default_nettype wire

/* File: sic_top_properties.sv */
// Purpose: Port-level checker for the safety interlock supervisor.
// Assumes: Single clock domain, synchronous active-low reset.
// Notes:   The red lamp stands for the loop-closed state.
`timescale 1ns/1ns
`default_nettype none
module sic_top_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic loop_in_n,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic run_active,
    input wire logic external_trigger_armed_mode,
    input wire logic test_object_supply,
    input wire logic lamp_red,
    input wire logic lamp_green,
    input wire logic open_symbol,
    input wire logic ilk_out_n,
    input wire logic msg_valid,
    input wire logic [7:0] msg_code
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_lamp_pair: assert property (lamp_red != lamp_green)
        else $error("lamps not complementary");
    chk_symbol_output: assert property (open_symbol == lamp_green && ilk_out_n == lamp_green)
        else $error("symbol or chained output disagrees with loop");
    chk_code_state: assert property (msg_code == (lamp_red ? 8'h00 : 8'h06))
        else $error("status code wrong");
    chk_msg_change: assert property (msg_valid == $changed(lamp_red))
        else $error("message pulse not tied to loop change");
    chk_mode_closed: assert property (run_active || external_trigger_armed_mode |-> lamp_red)
        else $error("high voltage mode with loop open");
    chk_supply_closed: assert property (test_object_supply |-> lamp_red)
        else $error("supply on with loop open");
    chk_open_fast: assert property ($rose(loop_in_n) && lamp_red |-> ##[1:3] !lamp_red)
        else $error("loop opening not acted on in time");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
endmodule
bind sic_top sic_top_checker u_chk (.aclk(aclk), .aresetn(aresetn), .loop_in_n(loop_in_n),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .run_active(run_active), .external_trigger_armed_mode(external_trigger_armed_mode),
    .test_object_supply(test_object_supply), .lamp_red(lamp_red), .lamp_green(lamp_green),
    .open_symbol(open_symbol), .ilk_out_n(ilk_out_n), .msg_valid(msg_valid),
    .msg_code(msg_code));
`default_nettype wire

/* File: tb_sic_top.sv */
// Purpose: Register-level bench for the safety interlock supervisor.
// Assumes: Debounce shortened to 4 cycles.
// Notes:   Each loop-opening cause is tried in turn, alternately from run and from external-trigger armed mode.
`timescale 1ns/1ns
`default_nettype none
`include "sic_cfg.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_sic_top;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [2:0] open_req = 3'b111;
    logic [3:0] wstrb = 4'hF;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, msg_code;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic [1:0] bresp, rresp;
    logic loop_in_n, status_n, estop_n, awready, wready, bvalid, arready, rvalid;
    logic run_active, armed, supply, lamp_red, lamp_green, symbol, periph_on, through;
    logic ilk_out_n, msg_valid;
    int n_fail = 0, samples_checked = 0;
    sic_contacts u_far (.aclk(aclk), .open_req(open_req), .loop_in_n(loop_in_n),
        .loop_status_n(status_n), .estop_released_n(estop_n));
    sic_top #(.DEB_CYCLES(16'h0004)) uut (.aclk(aclk), .aresetn(aresetn),
        .loop_in_n(loop_in_n), .loop_status_n(status_n), .estop_released_n(estop_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .run_active(run_active), .external_trigger_armed_mode(armed),
        .test_object_supply(supply), .lamp_red(lamp_red), .lamp_green(lamp_green),
        .open_symbol(symbol), .periph_on(periph_on), .loop_through(through),
        .ilk_out_n(ilk_out_n), .msg_valid(msg_valid), .msg_code(msg_code));
    initial begin
        forever #20 aclk = ~aclk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        if (n == 60) begin n_fail++; close_out(); end
        `CHK(bresp, er)
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        if (n == 60) begin n_fail++; close_out(); end
        `CHK(rdata & m, e)
        `CHK(rresp, er)
    endtask
    task automatic wait_red(input logic e);
        int n;
        for (n = 0; n < 60 && lamp_red !== e; n++) @(posedge aclk);
        if (n == 60) begin n_fail++; close_out(); end
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        bus_rd(`SIC_OFF_STAT, 32'h00060E60, 32'hFFFFFFFF, `SIC_RESP_OKAY);
        bus_rd(8'h10, 32'h0, 32'hFFFFFFFF, `SIC_RESP_SLVERR);
        bus_wr(8'h10, 32'h1, `SIC_RESP_SLVERR);
        bus_wr(`SIC_OFF_CMD, 32'h9, `SIC_RESP_OKAY);
        `CHK({run_active, supply}, 2'b00)
        bus_rd(`SIC_OFF_EVT, 32'h2, 32'hF, `SIC_RESP_OKAY);
        bus_wr(`SIC_OFF_CTRL, 32'h1, `SIC_RESP_OKAY);
        `CHK(periph_on, 1'b1)
        open_req <= 3'b000;
        wait_red(1'b1);
        `CHK({lamp_green, symbol, ilk_out_n, through, msg_code}, 12'h100)
        for (int c = 0; c < 4; c++) begin
            bus_wr(`SIC_OFF_EVT, 32'hF, `SIC_RESP_OKAY);
            bus_wr(`SIC_OFF_CMD, c[0] ? 32'hA : 32'h9, `SIC_RESP_OKAY);
            `CHK({run_active, armed, supply}, {~c[0], c[0], 1'b1})
            if (c < 3) open_req[c] <= 1'b1;
            else bus_wr(`SIC_OFF_CTRL, 32'h3, `SIC_RESP_OKAY);
            wait_red(1'b0);
            `CHK({run_active, armed, supply, symbol}, 4'h1)
            if (c >= 2) `CHK(through, 1'b0)
            bus_rd(`SIC_OFF_EVT, 32'hD, 32'hFFFFFFFF, `SIC_RESP_OKAY);
            bus_wr(`SIC_OFF_CMD, c[0] ? 32'hA : 32'h9, `SIC_RESP_OKAY);
            `CHK({run_active, armed, supply}, 3'h0)
            open_req <= 3'b000;
            if (c == 3) bus_wr(`SIC_OFF_CTRL, 32'h1, `SIC_RESP_OKAY);
            wait_red(1'b1);
            `CHK(run_active, 1'b0)
        end
        bus_rd(`SIC_OFF_CTRL, 32'h1, 32'hFFFFFFFF, `SIC_RESP_OKAY);
        bus_wr(`SIC_OFF_CMD, 32'h1B, `SIC_RESP_OKAY);
        `CHK({run_active, armed, supply}, 3'b100)
        bus_wr(`SIC_OFF_CMD, 32'hF, `SIC_RESP_OKAY);
        `CHK({run_active, armed, supply}, 3'b001)
        wstrb <= 4'hE;
        bus_wr(`SIC_OFF_CMD, 32'h2, `SIC_RESP_OKAY);
        wstrb <= 4'hF;
        `CHK({run_active, armed, supply}, 3'b001)
        bus_wr(`SIC_OFF_STAT, 32'h0, `SIC_RESP_OKAY);
        bus_rd(`SIC_OFF_CMD, 32'h0, 32'hFFFFFFFF, `SIC_RESP_OKAY);
        bus_wr(`SIC_OFF_CMD, 32'h10, `SIC_RESP_OKAY);
        `CHK({run_active, armed, supply}, 3'b000)
        bus_wr(`SIC_OFF_CTRL, 32'h0, `SIC_RESP_OKAY);
        `CHK(periph_on, 1'b0)
        close_out();
    end
endmodule
`default_nettype wire
